// [posc_pkg.sv]
/*
  types shared by the overcurrent sense top and its per-port detector.
  assumes posc_regs.svh for the field widths.
*/
`default_nettype none
`include "posc_regs.svh"

package posc_pkg;

  // ---------------------------------------------------------------
  // detector configuration and state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] lockout;
    logic [`POSC_MIN_WIDTH_MSB:0] min_width;
    logic [7:0] window;
  } posc_cfg_type;

  typedef enum logic [1:0] {
    POSC_OFF,
    POSC_LOCKOUT,
    POSC_ACTIVE
  } posc_det_state_type;

endpackage : posc_pkg

`default_nettype wire

// [posc_port_det.sv]
/*
  one overcurrent detector: lockout after power-on, single long low and
  double low inside a rolling window. assumes a synchronised sense level
  and a one-cycle 1 ms tick from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module posc_port_det (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic en_i,
  input wire logic sense_i,
  input wire posc_pkg::posc_cfg_type cfg_i,
  output logic oc_o,
  output logic lockout_o
);
  import posc_pkg::*;

  posc_det_state_type state;
  logic [7:0] lock_ms;
  logic [3:0] run_ms;
  logic [7:0] win_ms;
  logic win_armed;
  logic prev_low;
  logic fired;
  logic active;
  logic low;
  logic new_group;
  logic hit;

  assign active = (state == POSC_ACTIVE);
  assign low = active && !sense_i;
  assign new_group = low && !prev_low;
  assign hit = (low && !fired && (run_ms >= cfg_i.min_width)) || (new_group && win_armed);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en_i)
      state <= POSC_OFF;
    else
      case (state)
        POSC_OFF: state <= POSC_LOCKOUT;
        POSC_LOCKOUT:
          if (lock_ms >= cfg_i.lockout)
            state <= POSC_ACTIVE;
        POSC_ACTIVE: state <= POSC_ACTIVE;
        default: state <= POSC_OFF;
      endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || state != POSC_LOCKOUT)
      lock_ms <= 8'h00;
    else if (tick_i && lock_ms != 8'hFF)
      lock_ms <= lock_ms + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !low)
      run_ms <= 4'h0;
    else if (tick_i && run_ms != 4'hF)
      run_ms <= run_ms + 4'h1;
  end

  // one report per low run, so a held low does not flood the flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !low)
      fired <= 1'b0;
    else if (hit)
      fired <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !active)
      prev_low <= 1'b0;
    else
      prev_low <= low;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !active || hit)
    begin
      win_armed <= 1'b0;
      win_ms <= 8'h00;
    end
    else if (new_group)
    begin
      win_armed <= 1'b1;
      win_ms <= 8'h00;
    end
    else if (win_armed && win_ms >= cfg_i.window)
      win_armed <= 1'b0;
    else if (win_armed && tick_i)
      win_ms <= win_ms + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      oc_o <= 1'b0;
      lockout_o <= 1'b0;
    end
    else
    begin
      oc_o <= hit;
      lockout_o <= (state == POSC_LOCKOUT);
    end
  end

endmodule : posc_port_det

`default_nettype wire

// [posc_regs.svh]
/*
  constants of the port overcurrent sense block: register indices, reset
  values, field positions and timing. assumes a 10 MHz system clock.
*/
`ifndef POSC_REGS_SVH
`define POSC_REGS_SVH

`define POSC_NUM_PORTS 6

// ---------------------------------------------------------------
// register indices, byte address is four times the index
// ---------------------------------------------------------------
`define POSC_IDX_LOCKOUT 14'h30E1
`define POSC_IDX_MIN_WIDTH 14'h30EA
`define POSC_IDX_WINDOW 14'h30EB
`define POSC_IDX_POWER 14'h30F0
`define POSC_IDX_OC_STATUS 14'h30F1
`define POSC_IDX_MODE 14'h30F2
`define POSC_IDX_LOCK_STATE 14'h30F3
`define POSC_IDX_SENSE 14'h30F4

// ---------------------------------------------------------------
// reset values and fields
// ---------------------------------------------------------------
`define POSC_RST_LOCKOUT 8'h0A
`define POSC_RST_MIN_WIDTH 4'h5
`define POSC_RST_WINDOW 8'h14
`define POSC_MIN_WIDTH_MSB 3
`define POSC_MODE_GANG_BIT 0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define POSC_TICK_MS 1
`define POSC_CLK_KHZ 10000
`define POSC_TICK_CYCLES (`POSC_TICK_MS * `POSC_CLK_KHZ)

`endif

// [posc_switch_model.sv]
/* external power switch or fuse on one or more control pins.
   assumes the bench raises fault_i only to command an overcurrent. */
`timescale 1ns/1ps
`default_nettype none
module posc_switch_model #(
  parameter int N = 1
) (
  input wire logic clk_i,
  input wire logic [N-1:0] drv_i,
  input wire logic [N-1:0] oe_n_i,
  input wire logic [N-1:0] pullup_i,
  input wire logic [N-1:0] fault_i,
  output logic [N-1:0] level_o
);
  logic [N-1:0] last;
  // fault pulls low at once: fuse setups have no power-good delay
  // a released pin with no pull-up floats, so show the opposite level
  always_comb
    for (int i = 0; i < N; i++)
      level_o[i] = !oe_n_i[i] ? drv_i[i] : !fault_i[i] && (pullup_i[i] || !last[i]);
  always_ff @(posedge clk_i)
    last <= level_o;
endmodule : posc_switch_model
`default_nettype wire

// [posc_tb_top.sv]
/* self-checking bench of posc_top with a switch model on every pin.
   assumes TICK_CYCLES of 10, so one ms is ten cycles. */
`timescale 1ns/1ps
`default_nettype none
`include "posc_regs.svh"
module posc_tb_top;
  localparam int TC = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = '0;
  logic [31:0] dw = '0;
  logic [31:0] dr, q;
  logic ack, g_in, g_o, g_oe_n, g_pu;
  logic g_fault = 1'b0;
  logic [5:0] pin_in, pin_o, oe_n, pu, flag;
  logic [5:0] clr = '0;
  logic [5:0] fault = '0;
  logic [3:0] sel = 4'hF;
  logic [7:0] r;
  int seed, miscompares = 0, num_checks = 0;
  posc_top #(.TICK_CYCLES(TC)) i_posc_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .port_power_sense_pin_i(pin_in),
    .port_power_sense_pin_o(pin_o), .port_power_sense_pin_oe_n_o(oe_n),
    .port_pullup_en_o(pu), .shared_port_power_pin_i(g_in), .shared_port_power_pin_o(g_o),
    .shared_port_power_pin_oe_n_o(g_oe_n), .shared_pullup_en_o(g_pu),
    .port_oc_clear_i(clr), .port_oc_flag_o(flag));
  posc_switch_model #(.N(6)) i_posc_switch_model (.clk_i(clk), .drv_i(pin_o),
    .oe_n_i(oe_n), .pullup_i(pu), .fault_i(fault), .level_o(pin_in));
  posc_switch_model #(.N(1)) i_posc_switch_model_gang (.clk_i(clk), .drv_i(g_o),
    .oe_n_i(g_oe_n), .pullup_i(g_pu), .fault_i(g_fault), .level_o(g_in));
  initial
    forever #50 clk = ~clk;
  function automatic logic [31:0] wid(input logic [31:0] d);
    return {28'h0, d[3:0]};
  endfunction : wid
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic fl(input string nm, input logic [5:0] e);
    chk(nm, {26'h0, flag}, {26'h0, e});
  endtask : fl
  // request raised just after an edge and held until ack is sampled
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    @(posedge clk);
    // no limit here: the watchdog ends a hung wait
    while (ack !== 1'b1)
      @(posedge clk);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    bus(1'b1, {i, 2'b00}, d);
  endtask : wr
  task automatic rd(input logic [13:0] i, input logic [31:0] e, input string nm);
    bus(1'b0, {i, 2'b00}, 32'h0);
    chk(nm, q, e);
  endtask : rd
  task automatic ms(input int n);
    repeat (n * TC) @(posedge clk);
  endtask : ms
  // short lows, well under the single-pulse width
  task automatic pulse(input logic [5:0] m);
    fault <= m;
    repeat (5) @(posedge clk);
    fault <= 6'h00;
    ms(3);
  endtask : pulse
  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
  initial
  begin
    seed = 32'haee42a0d;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(`POSC_IDX_LOCKOUT, 32'h0A, "lockout");
    rd(`POSC_IDX_MIN_WIDTH, 32'h05, "width");
    rd(`POSC_IDX_WINDOW, 32'h14, "window");
    rd(`POSC_IDX_MODE, 32'h00, "mode");
    chk("drive", {14'h0, oe_n, pu, pin_o}, 32'h0);
    wr(`POSC_IDX_MIN_WIDTH, 32'hFF);
    rd(`POSC_IDX_MIN_WIDTH, wid(32'hFF), "width");
    bus(1'b0, 16'hC3C6, 32'h0);
    chk("refused", q, 32'h0);
    repeat (4)
    begin
      r = 8'($random(seed));
      if (r == 8'h00)
        r = 8'h01;
      wr(`POSC_IDX_LOCKOUT, {24'h0, r});
      rd(`POSC_IDX_LOCKOUT, {24'h0, r}, "lockout");
      wr(`POSC_IDX_WINDOW, {24'h0, r[3:0], r[7:4]});
      rd(`POSC_IDX_WINDOW, {24'h0, r[3:0], r[7:4]}, "window");
      wr(`POSC_IDX_POWER, {26'h0, r[5:0]});
      chk("pins", {20'h0, oe_n, pu}, {20'h0, r[5:0], r[5:0]});
    end
    wr(`POSC_IDX_LOCKOUT, 32'h04);
    wr(`POSC_IDX_WINDOW, 32'h14);
    wr(`POSC_IDX_MIN_WIDTH, 32'h03);
    wr(`POSC_IDX_POWER, 32'h00);
    wr(`POSC_IDX_POWER, 32'h3F);
    fault <= 6'h3F;
    rd(`POSC_IDX_LOCK_STATE, 32'h3F, "lock state");
    rd(`POSC_IDX_SENSE, 32'h00, "sense low");
    ms(2);
    fault <= 6'h00;
    ms(4);
    fl("lockout", 6'h00);
    rd(`POSC_IDX_SENSE, 32'h3F, "sense high");
    rd(`POSC_IDX_POWER, 32'h3F, "power");
    fault <= 6'h02;
    ms(5);
    fault <= 6'h00;
    ms(1);
    fl("single", 6'h02);
    wr(`POSC_IDX_OC_STATUS, 32'h02);
    ms(1);
    fl("status clear", 6'h00);
    pulse(6'h0C);
    fl("one pulse", 6'h00);
    pulse(6'h04);
    fl("double", 6'h04);
    ms(16);
    pulse(6'h08);
    fl("late pulse", 6'h04);
    clr <= 6'h04;
    @(posedge clk);
    clr <= 6'h00;
    ms(1);
    fl("pin clear", 6'h00);
    wr(`POSC_IDX_POWER, 32'h00);
    wr(`POSC_IDX_MODE, 32'h01);
    wr(`POSC_IDX_POWER, 32'h01);
    chk("gang pins", {24'h0, g_oe_n, g_pu, pu}, 32'hFF);
    ms(5);
    g_fault <= 1'b1;
    ms(5);
    g_fault <= 1'b0;
    ms(1);
    fl("gang flags", 6'h3F);
    rd(`POSC_IDX_OC_STATUS, 32'h3F, "status");
    wr(`POSC_IDX_POWER, 32'h00);
    chk("off", {18'h0, oe_n, pu, g_oe_n, g_pu}, 32'h0);
    // reset in mid-run: flags, pins and settings go back to their defaults
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk("reset", {5'h0, flag, oe_n, pu, pin_o, g_o, g_oe_n, g_pu}, 32'h0);
    // a write without the low byte lane selected must be ignored
    sel <= 4'hE;
    wr(`POSC_IDX_LOCKOUT, 32'h55);
    sel <= 4'hF;
    rd(`POSC_IDX_LOCKOUT, 32'h0A, "lockout reset");
    rd(`POSC_IDX_MODE, 32'h00, "mode reset");
    results();
  end
endmodule : posc_tb_top
`default_nettype wire

// [posc_top.sv]
/*
  overcurrent sense and port power control for the downstream ports,
  individual or ganged, with a classic wishbone register slave.
  assumes sense pins are asynchronous and resolved open drain outside.
*/
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "posc_regs.svh"

module posc_top #(
  parameter int TICK_CYCLES = `POSC_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [`POSC_NUM_PORTS-1:0] port_power_sense_pin_i,
  output logic [`POSC_NUM_PORTS-1:0] port_power_sense_pin_o,
  output logic [`POSC_NUM_PORTS-1:0] port_power_sense_pin_oe_n_o,
  output logic [`POSC_NUM_PORTS-1:0] port_pullup_en_o,
  input wire logic shared_port_power_pin_i,
  output logic shared_port_power_pin_o,
  output logic shared_port_power_pin_oe_n_o,
  output logic shared_pullup_en_o,
  input wire logic [`POSC_NUM_PORTS-1:0] port_oc_clear_i,
  output logic [`POSC_NUM_PORTS-1:0] port_oc_flag_o
);
  import posc_pkg::*;

  localparam int NP = `POSC_NUM_PORTS;
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  function automatic logic posc_hit(input logic [15:0] adr, input logic [13:0] idx);
    posc_hit = (adr[15:2] == idx) && (adr[1:0] == 2'b00);
  endfunction : posc_hit

  posc_cfg_type cfg;
  logic [NP-1:0] power_en;
  logic gang_mode;
  logic [NP-1:0] oc_flags;
  logic [15:0] tick_cnt;
  logic tick;
  logic [NP:0] sense_meta;
  logic [NP:0] sense_sync;
  logic [NP:0] det_en;
  logic [NP:0] det_oc;
  logic [NP:0] det_lock;
  logic [NP-1:0] drive_on;
  logic req;
  logic wr;
  logic [NP-1:0] wb_clear;
  logic [NP-1:0] oc_set;
  logic [31:0] next_rdata;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];

  // ---------------------------------------------------------------
  // 1 ms tick
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick_cnt == TICK_LAST)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tick <= 1'b0;
    else
      tick <= (tick_cnt == TICK_LAST);
  end

  // ---------------------------------------------------------------
  // pin synchroniser, bit NP is the shared pin
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sense_meta <= '1;
      sense_sync <= '1;
    end
    else
    begin
      sense_meta <= {shared_port_power_pin_i, port_power_sense_pin_i};
      sense_sync <= sense_meta;
    end
  end

  // ---------------------------------------------------------------
  // detectors
  // ---------------------------------------------------------------
  // in ganged mode every port follows the shared power bit, since the
  // control pins may be tied together and must never fight
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_port
      assign drive_on[gi] = gang_mode ? power_en[0] : power_en[gi];
      assign det_en[gi] = !gang_mode && power_en[gi];
    end
  endgenerate
  assign det_en[NP] = gang_mode && power_en[0];

  generate
    for (gi = 0; gi <= NP; gi++)
    begin : g_det
      posc_port_det u_det (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .en_i(det_en[gi]),
        .sense_i(sense_sync[gi]),
        .cfg_i(cfg),
        .oc_o(det_oc[gi]),
        .lockout_o(det_lock[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_power_sense_pin_o <= '0;
      port_power_sense_pin_oe_n_o <= '0;
      port_pullup_en_o <= '0;
      shared_port_power_pin_o <= 1'b0;
      shared_port_power_pin_oe_n_o <= 1'b0;
      shared_pullup_en_o <= 1'b0;
    end
    else
    begin
      // driven low while off, released to the pull-up when powered
      port_power_sense_pin_o <= '0;
      port_power_sense_pin_oe_n_o <= drive_on;
      port_pullup_en_o <= drive_on;
      shared_port_power_pin_o <= 1'b0;
      shared_port_power_pin_oe_n_o <= det_en[NP];
      shared_pullup_en_o <= det_en[NP];
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg.lockout <= `POSC_RST_LOCKOUT;
      cfg.min_width <= `POSC_RST_MIN_WIDTH;
      cfg.window <= `POSC_RST_WINDOW;
    end
    else if (wr)
    begin
      if (posc_hit(wb_adr_i, `POSC_IDX_LOCKOUT))
        cfg.lockout <= wb_dat_i[7:0];
      if (posc_hit(wb_adr_i, `POSC_IDX_MIN_WIDTH))
        cfg.min_width <= wb_dat_i[`POSC_MIN_WIDTH_MSB:0];
      if (posc_hit(wb_adr_i, `POSC_IDX_WINDOW))
        cfg.window <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      power_en <= '0;
      gang_mode <= 1'b0;
    end
    else if (wr)
    begin
      if (posc_hit(wb_adr_i, `POSC_IDX_POWER))
        power_en <= wb_dat_i[NP-1:0];
      if (posc_hit(wb_adr_i, `POSC_IDX_MODE))
        gang_mode <= wb_dat_i[`POSC_MODE_GANG_BIT];
    end
  end

  // ---------------------------------------------------------------
  // sticky overcurrent flags, a new event beats a same-cycle clear
  // ---------------------------------------------------------------
  assign wb_clear = (wr && posc_hit(wb_adr_i, `POSC_IDX_OC_STATUS)) ? wb_dat_i[NP-1:0] : '0;
  assign oc_set = det_oc[NP-1:0] | {NP{det_oc[NP]}};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      oc_flags <= '0;
    else
      oc_flags <= (oc_flags & ~(wb_clear | port_oc_clear_i)) | oc_set;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_oc_flag_o <= '0;
    else
      port_oc_flag_o <= (oc_flags & ~(wb_clear | port_oc_clear_i)) | oc_set;
  end

  // ---------------------------------------------------------------
  // wishbone read and acknowledge
  // ---------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (posc_hit(wb_adr_i, `POSC_IDX_LOCKOUT))
      next_rdata[7:0] = cfg.lockout;
    else if (posc_hit(wb_adr_i, `POSC_IDX_MIN_WIDTH))
      next_rdata[`POSC_MIN_WIDTH_MSB:0] = cfg.min_width;
    else if (posc_hit(wb_adr_i, `POSC_IDX_WINDOW))
      next_rdata[7:0] = cfg.window;
    else if (posc_hit(wb_adr_i, `POSC_IDX_POWER))
      next_rdata[NP-1:0] = power_en;
    else if (posc_hit(wb_adr_i, `POSC_IDX_OC_STATUS))
      next_rdata[NP-1:0] = oc_flags;
    else if (posc_hit(wb_adr_i, `POSC_IDX_MODE))
      next_rdata[`POSC_MODE_GANG_BIT] = gang_mode;
    else if (posc_hit(wb_adr_i, `POSC_IDX_LOCK_STATE))
      next_rdata[NP:0] = det_lock;
    else if (posc_hit(wb_adr_i, `POSC_IDX_SENSE))
      next_rdata[NP:0] = sense_sync;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
        wb_dat_o <= next_rdata;
    end
  end

endmodule : posc_top

`default_nettype wire

// [posc_top_assertions.sv]
/* checker of posc_top: bus answer, pin drive, lockout and sticky flags.
   assumes a bind to posc_top and a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "posc_regs.svh"
module posc_top_assertions #(
  parameter int TICK_CYCLES = `POSC_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [`POSC_NUM_PORTS-1:0] port_power_sense_pin_o,
  input wire logic [`POSC_NUM_PORTS-1:0] port_power_sense_pin_oe_n_o,
  input wire logic [`POSC_NUM_PORTS-1:0] port_pullup_en_o,
  input wire logic shared_port_power_pin_o,
  input wire logic shared_port_power_pin_oe_n_o,
  input wire logic shared_pullup_en_o,
  input wire logic [`POSC_NUM_PORTS-1:0] port_oc_clear_i,
  input wire logic [`POSC_NUM_PORTS-1:0] port_oc_flag_o
);
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wr_en = take && wb_we_i && wb_sel_i[0];
  logic [7:0] lock;
  logic gang;
  int on_cnt;
  // shadow of the two settings that change what the pins may do
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lock <= `POSC_RST_LOCKOUT;
      gang <= 1'b0;
    end
    else if (wr_en && wb_adr_i == {`POSC_IDX_LOCKOUT, 2'b00})
      lock <= wb_dat_i[7:0];
    else if (wr_en && wb_adr_i == {`POSC_IDX_MODE, 2'b00})
      gang <= wb_dat_i[`POSC_MODE_GANG_BIT];
  end
  always_ff @(posedge clk_i)
    on_cnt <= (rst_i || !port_pullup_en_o[0]) ? 0 : on_cnt + 1;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_once: assert property (
    take |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
  a_refused_zero: assert property (
    take && !wb_we_i && wb_adr_i[1:0] != 2'b00 |=> wb_dat_o == '0)
    else $error("refused read not zero");
  a_width_reserved: assert property (
    take && !wb_we_i && wb_adr_i == {`POSC_IDX_MIN_WIDTH, 2'b00} |=> wb_dat_o[31:4] == '0)
    else $error("width upper bits not zero");
  a_release_pullup: assert property (
    port_power_sense_pin_oe_n_o == port_pullup_en_o && port_power_sense_pin_o == '0
    && !shared_port_power_pin_o && shared_port_power_pin_oe_n_o == shared_pullup_en_o)
    else $error("pin drive and pull-up disagree");
  // power register lands at the taking edge, the pin flops one edge later
  a_power_latency: assert property (
    wr_en && wb_adr_i == {`POSC_IDX_POWER, 2'b00} |=> ##1 port_pullup_en_o ==
    (gang ? {`POSC_NUM_PORTS{$past(wb_dat_i[0], 2)}} : $past(wb_dat_i[5:0], 2)))
    else $error("pull-ups do not follow power write");
  a_gang_follow: assert property (
    shared_pullup_en_o |-> &port_pullup_en_o && shared_port_power_pin_oe_n_o)
    else $error("ganged power not on every port");
  a_flag_sticky: assert property (
    !wb_cyc_i && !$past(wb_cyc_i) && port_oc_clear_i == '0 && $past(port_oc_clear_i) == '0
    |=> (port_oc_flag_o & $past(port_oc_flag_o)) == $past(port_oc_flag_o))
    else $error("flag dropped without clear");
  a_lockout_quiet: assert property (
    $rose(port_oc_flag_o[0]) && port_pullup_en_o[0] |-> on_cnt >= (int'(lock) - 1) * TICK_CYCLES)
    else $error("flag inside lockout");
  cover property ($rose(port_oc_flag_o[1]));
  cover property ($rose(shared_pullup_en_o));
  cover property (&port_oc_flag_o);
endmodule : posc_top_assertions
bind posc_top posc_top_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_posc_top_assertions (.*);
`default_nettype wire
